// ### verilog/srw_pkg.sv
// Purpose: shared constants and types for the stop recovery and watchdog block
// Assumes: 125 MHz system clock, APB register access with 32-bit data
// Notes:   register indices give byte address index*4
package srw_pkg;

  // ==========================================================================
  // clock and timing
  localparam int CLK_MHZ         = 125;
  localparam int NS_PER_US       = 1000;
  localparam int WIN_CYC         = 60;

  // ==========================================================================
  // register indices
  localparam logic [5:0] IDX_SMR    = 6'h0B;
  localparam logic [5:0] IDX_STOP_RECOVERY_CONTROL_TWO   = 6'h0D;
  localparam logic [5:0] IDX_WDTM   = 6'h0F;
  localparam logic [5:0] IDX_STATUS = 6'h10;

  // ==========================================================================
  // field layout
  localparam int SMR_SRC_LSB   = 2;
  localparam int SMR_DELAY_BIT = 5;
  localparam int SMR_POL_BIT   = 6;
  localparam int SMR_FLAG_BIT  = 7;
  localparam int WDT_PER_LSB   = 0;
  localparam int WDT_HALT_BIT  = 2;
  localparam int WDT_STOP_BIT  = 3;
  localparam int WDT_CLK_BIT   = 4;
  localparam int STS_WDT_ON    = 0;
  localparam int STS_WIN_OPEN  = 1;
  localparam int STS_STOPPED   = 2;
  localparam int STS_LOWV      = 3;
  localparam int STS_RESET     = 4;

  // ==========================================================================
  // reset values and write masks
  localparam logic [7:0] SMR_RST  = 8'h20;
  localparam logic [7:0] STOP_RECOVERY_CONTROL_TWO_RST = 8'h00;
  localparam logic [7:0] WDTM_RST = 8'h0D;
  localparam logic [6:0] SMR_WMASK  = 7'h7F;
  localparam logic [7:0] STOP_RECOVERY_CONTROL_TWO_WMASK = 8'h03;
  localparam logic [7:0] WDTM_WMASK = 8'h1F;

  // ==========================================================================
  // recovery source codes
  localparam logic [2:0] SRC_RESET = 3'h0;
  localparam logic [2:0] SRC_P30   = 3'h1;
  localparam logic [2:0] SRC_P31   = 3'h2;
  localparam logic [2:0] SRC_P32   = 3'h3;
  localparam logic [2:0] SRC_P33   = 3'h4;
  localparam logic [2:0] SRC_P27   = 3'h5;
  localparam logic [2:0] SRC_NOR4  = 3'h6;
  localparam logic [2:0] SRC_NOR8  = 3'h7;
  localparam logic [1:0] SRC2_AND4 = 2'h1;
  localparam logic [1:0] SRC2_AND8 = 2'h2;

  // ==========================================================================
  // watchdog periods in ticks
  localparam logic [11:0] WDT_T0 = 12'h080;
  localparam logic [11:0] WDT_T1 = 12'h100;
  localparam logic [11:0] WDT_T2 = 12'h200;
  localparam logic [11:0] WDT_T3 = 12'h800;

  function automatic logic [11:0] srw_wdt_limit(input logic [1:0] per);
    unique case (per)
      2'h0: srw_wdt_limit = WDT_T0;
      2'h1: srw_wdt_limit = WDT_T1;
      2'h2: srw_wdt_limit = WDT_T2;
      2'h3: srw_wdt_limit = WDT_T3;
    endcase
  endfunction

  // ==========================================================================
  // types
  typedef enum logic [3:0] {
    ST_RUN   = 4'h1,
    ST_STOP  = 4'h2,
    ST_DELAY = 4'h4,
    ST_LOWV  = 4'h8
  } srw_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } srw_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } srw_apb_rsp_t;

  typedef struct packed {
    logic [7:0] pin;
    logic [7:0] pout;
    logic [7:0] poe;
  } srw_port2_t;

endpackage

// ### verilog/srw_wake_detect.sv
// Purpose: recovery source selection and level compare
// Assumes: port levels synchronous to the clock
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
module srw_wake_detect
  import srw_pkg::*;
(
  // configuration
  input  wire logic [2:0] i_src,
  input  wire logic [1:0] i_src2,
  input  wire logic       i_pol,
  input  wire logic       i_analog,
  // ports
  input  wire srw_port2_t i_p2,
  input  wire logic [3:0] i_p3,
  // result
  output logic            o_wake
);
  logic [7:0] p2_eff;
  logic       lvl;
  logic       lvl2;
  logic       idle;

  // ==========================================================================
  // port 2 effective level
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_p2
      assign p2_eff[g] = i_p2.poe[g] ? i_p2.pout[g] : i_p2.pin[g];
    end
  endgenerate

  // ==========================================================================
  // source select
  assign idle = ~i_pol;
  always_comb begin
    unique case (i_src)
      SRC_RESET: lvl = idle;
      SRC_P30:   lvl = i_p3[0];
      SRC_P31:   lvl = i_analog ? idle : i_p3[1];
      SRC_P32:   lvl = i_analog ? idle : i_p3[2];
      SRC_P33:   lvl = i_analog ? idle : i_p3[3];
      SRC_P27:   lvl = p2_eff[7];
      SRC_NOR4:  lvl = ~|p2_eff[3:0];
      SRC_NOR8:  lvl = ~|p2_eff;
    endcase
    unique case (i_src2)
      SRC2_AND4: lvl2 = &p2_eff[3:0];
      SRC2_AND8: lvl2 = &p2_eff;
      default:   lvl2 = idle;
    endcase
  end

  assign o_wake = (lvl == i_pol) || (lvl2 == i_pol);
endmodule
`default_nettype wire

// ### verilog/srw_wdt_timer.sv
// Purpose: retriggerable watchdog counter
// Assumes: i_tick is a one-cycle pulse of the selected source
// Notes:   o_timeout pulses one cycle at terminal count
`timescale 1ns/1ps
`default_nettype none
module srw_wdt_timer (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // control
  input  wire logic        i_restart,
  input  wire logic        i_run,
  input  wire logic        i_tick,
  input  wire logic [11:0] i_limit,
  // result
  output logic             o_timeout
);
  typedef struct packed {
    logic [11:0] cnt;
    logic        timeout;
  } srw_tmr_t;

  srw_tmr_t r;
  srw_tmr_t next_r;

  // ==========================================================================
  // counter
  always_comb begin
    next_r = r;
    next_r.timeout = 1'b0;
    if (i_restart) begin
      next_r.cnt = '0;
    end else if (i_run && i_tick) begin
      if (r.cnt == i_limit - 12'h001) begin
        next_r.cnt = '0;
        next_r.timeout = 1'b1;
      end else begin
        next_r.cnt = r.cnt + 12'h001;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign o_timeout = r.timeout;
endmodule
`default_nettype wire

// ### verilog/srw_top.sv
// Purpose: stop mode recovery control and watchdog with APB registers
// Assumes: core events are one-cycle pulses synchronous to i_clk
// Notes:   o_reset is the global reset to the core
//
// Behaviour
// - three-bit source field selects reset only, port 3/2 bits or NOR groups
// - port 3 bits 1 to 3 never wake while in analog comparator mode
// - delay select bit high applies power-on delay after wake; default 1
// - polarity bit chooses high or low level wake; default 0; both registers
// - start flag reads 0 after power-on or watchdog reset, set entering stop
// - port 2 pins driven as outputs feed their output level to detection
// - second register selects reset only, AND of port 2 bits 0-3 or 0-7
// - watchdog is a retriggerable one-shot, started and restarted by refresh
// - watchdog refresh also updates zero, sign and overflow flags
// - watchdog mode writable first 60 clocks after reset or wake; never read
// - period codes give 128, 256, 512 or 2048 ticks; reset picks code 01
// - halt bit keeps watchdog counting in halt; default 1
// - stop bit keeps watchdog running in stop; needs RC clock; default 1
// - clock source bit picks RC oscillator at 0, crystal pin at 1
// - permanent option runs watchdog from reset, unstoppable on RC clock
// - timeout in stop keeps registers and always applies power-on delay
// - global reset held while supply is below low voltage trip point
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module srw_top
  import srw_pkg::*;
#(
  parameter int POR_DELAY_NS  = 1000,
  parameter bit PERMANENT_WDT = 1'b0
) (
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_nrst,
  // register bus
  input  wire srw_pkg::srw_apb_req_t i_apb,
  output srw_pkg::srw_apb_rsp_t      o_apb,
  // core events
  input  wire logic                  i_wdt_refresh,
  input  wire logic                  i_stop_req,
  input  wire logic                  i_halt,
  // clock ticks and supply monitor
  input  wire logic                  i_rc_tick,
  input  wire logic                  i_xtal_tick,
  input  wire logic                  i_low_voltage,
  // ports
  input  wire srw_pkg::srw_port2_t   i_port2,
  input  wire logic [3:0]            i_port3,
  input  wire logic                  i_analog_mode,
  // outputs to core
  output logic                       o_reset,
  output logic                       o_stopped,
  output logic                       o_zsv_we,
  output logic                       o_wake
);
  import srw_pkg::*;

  // ==========================================================================
  // derived timing
  localparam int POR_CYC_RAW = (POR_DELAY_NS * CLK_MHZ + NS_PER_US - 1)
                               / NS_PER_US;
  localparam int POR_CYC     = (POR_CYC_RAW < 1) ? 1 : POR_CYC_RAW;
  localparam int DW          = $clog2(POR_CYC + 1) + 1;
  localparam logic [DW-1:0] DLY_POR  = DW'(POR_CYC);
  localparam logic [DW-1:0] DLY_FAST = DW'(1);
  localparam logic [5:0]    WIN_INIT = 6'(WIN_CYC);

  typedef struct packed {
    srw_state_t   st;
    logic [7:0]   stop_recovery_control;
    logic [7:0]   stop_recovery_control_two;
    logic [7:0]   wdtm;
    logic         wdt_on;
    logic         warm;
    logic [5:0]   win;
    logic [DW-1:0] dly;
    srw_apb_rsp_t rsp;
    logic         rst_out;
    logic         zsv_we;
    logic         wake;
  } srw_regs_t;

  srw_regs_t r;
  srw_regs_t next_r;

  logic        wake_lvl;
  logic        timeout;
  logic        tmr_restart;
  logic        tmr_run;
  logic        tick;
  logic        perm_rc;
  logic        setup;
  logic        access;
  logic        wr;
  logic [31:0] rd;

  // ==========================================================================
  // address decode
  function automatic logic is_reg(input logic [7:0] a, input logic [5:0] idx);
    is_reg = (a[1:0] == 2'h0) && (a[7:2] == idx);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = is_reg(a, IDX_SMR) || is_reg(a, IDX_STOP_RECOVERY_CONTROL_TWO) ||
             is_reg(a, IDX_WDTM) || is_reg(a, IDX_STATUS);
  endfunction

  // ==========================================================================
  // wake detection
  srw_wake_detect u_wake (
    .i_src    (r.stop_recovery_control[SMR_SRC_LSB +: 3]),
    .i_src2   (r.stop_recovery_control_two[1:0]),
    .i_pol    (r.stop_recovery_control[SMR_POL_BIT]),
    .i_analog (i_analog_mode),
    .i_p2     (i_port2),
    .i_p3     (i_port3),
    .o_wake   (wake_lvl)
  );

  // ==========================================================================
  // watchdog counter control
  assign perm_rc = PERMANENT_WDT && !r.wdtm[WDT_CLK_BIT];
  // crystal stops in stop mode, so only the RC tick can advance there
  assign tick = r.wdtm[WDT_CLK_BIT] ?
                (i_xtal_tick && r.st != ST_STOP) : i_rc_tick;
  assign tmr_restart = (r.st == ST_DELAY) || (r.st == ST_LOWV) ||
                       (r.st == ST_RUN && i_wdt_refresh);
  always_comb begin
    tmr_run = 1'b0;
    if (r.wdt_on) begin
      unique case (r.st)
        ST_RUN:   tmr_run = !i_halt || r.wdtm[WDT_HALT_BIT] || perm_rc;
        ST_STOP:  tmr_run = r.wdtm[WDT_STOP_BIT] || perm_rc;
        ST_DELAY: tmr_run = 1'b0;
        ST_LOWV:  tmr_run = 1'b0;
      endcase
    end
  end

  srw_wdt_timer u_tmr (
    .i_clk     (i_clk),
    .i_nrst    (i_nrst),
    .i_restart (tmr_restart),
    .i_run     (tmr_run),
    .i_tick    (tick),
    .i_limit   (srw_wdt_limit(r.wdtm[WDT_PER_LSB +: 2])),
    .o_timeout (timeout)
  );

  // ==========================================================================
  // read mux
  always_comb begin
    rd = '0;
    if (is_reg(i_apb.paddr, IDX_SMR)) begin
      rd[SMR_FLAG_BIT] = r.warm;
    end else if (is_reg(i_apb.paddr, IDX_STATUS)) begin
      rd[STS_WDT_ON]   = r.wdt_on;
      rd[STS_WIN_OPEN] = (r.win != 6'h00);
      rd[STS_STOPPED]  = (r.st == ST_STOP);
      rd[STS_LOWV]     = (r.st == ST_LOWV);
      rd[STS_RESET]    = r.rst_out;
    end
    // watchdog mode and second recovery register read as zero
  end

  assign setup  = i_apb.psel && !i_apb.penable;
  assign access = i_apb.psel && i_apb.penable && r.rsp.pready;
  assign wr     = access && i_apb.pwrite && mapped(i_apb.paddr);

  // ==========================================================================
  // next state
  always_comb begin
    next_r = r;
    next_r.zsv_we = 1'b0;
    next_r.wake   = 1'b0;

    // apb answer: one wait-free access phase after setup
    next_r.rsp.pready  = setup;
    next_r.rsp.pslverr = setup && !mapped(i_apb.paddr);
    next_r.rsp.prdata  = setup ? rd : '0;

    // register writes
    if (wr && is_reg(i_apb.paddr, IDX_SMR)) begin
      next_r.stop_recovery_control = {r.stop_recovery_control[SMR_FLAG_BIT], i_apb.pwdata[6:0] & SMR_WMASK};
    end
    if (wr && is_reg(i_apb.paddr, IDX_STOP_RECOVERY_CONTROL_TWO)) begin
      next_r.stop_recovery_control_two = i_apb.pwdata[7:0] & STOP_RECOVERY_CONTROL_TWO_WMASK;
    end
    if (wr && is_reg(i_apb.paddr, IDX_WDTM) && r.win != 6'h00 &&
        r.st == ST_RUN) begin
      next_r.wdtm = i_apb.pwdata[7:0] & WDTM_WMASK;
    end

    // write window counts down from the first instruction
    if (r.st == ST_RUN && r.win != 6'h00) begin
      next_r.win = r.win - 6'h01;
    end

    unique case (r.st)
      ST_RUN: begin
        if (i_wdt_refresh) begin
          next_r.wdt_on = 1'b1;
          next_r.zsv_we = 1'b1;
        end
        if (timeout) begin
          next_r.st      = ST_DELAY;
          next_r.dly     = DLY_POR;
          next_r.rst_out = 1'b1;
          next_r.warm    = 1'b0;
          next_r.stop_recovery_control     = SMR_RST;
          next_r.stop_recovery_control_two    = STOP_RECOVERY_CONTROL_TWO_RST;
          next_r.wdtm    = WDTM_RST;
          next_r.wdt_on  = PERMANENT_WDT;
        end else if (i_stop_req) begin
          next_r.st   = ST_STOP;
          next_r.warm = 1'b1;
        end
      end
      ST_STOP: begin
        if (timeout) begin
          // registers kept; delay forced regardless of select bit
          next_r.st      = ST_DELAY;
          next_r.dly     = DLY_POR;
          next_r.rst_out = 1'b1;
          next_r.warm    = 1'b0;
          next_r.wdt_on  = PERMANENT_WDT;
        end else if (wake_lvl) begin
          next_r.st      = ST_DELAY;
          next_r.wake    = 1'b1;
          next_r.rst_out = 1'b1;
          next_r.wdt_on  = PERMANENT_WDT;
          // fast wake relies on the source held five processor clocks
          next_r.dly = r.stop_recovery_control[SMR_DELAY_BIT] ? DLY_POR : DLY_FAST;
        end
      end
      ST_DELAY: begin
        if (r.dly <= DLY_FAST) begin
          next_r.st      = ST_RUN;
          next_r.rst_out = 1'b0;
          next_r.win     = WIN_INIT;
        end else begin
          next_r.dly = r.dly - DLY_FAST;
        end
      end
      ST_LOWV: begin
        if (!i_low_voltage) begin
          next_r.st  = ST_DELAY;
          next_r.dly = DLY_POR;
        end
      end
    endcase

    // supply monitor overrides everything but the delay count, flag update, wake pulse and apb answer
    if (i_low_voltage) begin
      next_r.st      = ST_LOWV;
      next_r.rst_out = 1'b1;
      next_r.warm    = 1'b0;
      next_r.stop_recovery_control     = SMR_RST;
      next_r.stop_recovery_control_two    = STOP_RECOVERY_CONTROL_TWO_RST;
      next_r.wdtm    = WDTM_RST;
      next_r.wdt_on  = PERMANENT_WDT;
      next_r.win     = '0;
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      r         <= '0;
      r.st      <= ST_DELAY;
      r.dly     <= DLY_POR;
      r.rst_out <= 1'b1;
      r.stop_recovery_control     <= SMR_RST;
      r.stop_recovery_control_two    <= STOP_RECOVERY_CONTROL_TWO_RST;
      r.wdtm    <= WDTM_RST;
      r.wdt_on  <= PERMANENT_WDT;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================================
  // outputs
  assign o_apb     = r.rsp;
  assign o_reset   = r.rst_out;
  assign o_stopped = (r.st == ST_STOP) ? 1'b1 : 1'b0;
  assign o_zsv_we  = r.zsv_we;
  assign o_wake    = r.wake;
endmodule
`default_nettype wire

// ### test/srw_top_monitor.sv
// Purpose: port-level checks of srw_top
// Assumes: one clock domain, reset active low
// Notes:   bound to every srw_top instance
`timescale 1ns/1ps
`default_nettype none
module srw_top_monitor
  import srw_pkg::*;
(
  // clock and reset
  input wire logic         i_clk,
  input wire logic         i_nrst,
  // register bus
  input wire srw_apb_req_t i_apb,
  input wire srw_apb_rsp_t o_apb,
  // core events and supply
  input wire logic         i_wdt_refresh,
  input wire logic         i_stop_req,
  input wire logic         i_low_voltage,
  // outputs to core
  input wire logic         o_reset,
  input wire logic         o_stopped,
  input wire logic         o_zsv_we,
  input wire logic         o_wake
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  // ==========================================================================
  // sequences
  sequence s_setup;
    i_apb.psel && !i_apb.penable;
  endsequence
  sequence s_live;
    !o_reset && !o_stopped && !i_low_voltage;
  endsequence
  sequence s_left_stop;
    o_stopped ##1 !o_stopped;
  endsequence

  // ==========================================================================
  // assertions
  chk_apb_answer: assert property (s_setup |=> o_apb.pready)
    else $error("no ready after setup");
  chk_ready_pulse: assert property (o_apb.pready |=> !o_apb.pready)
    else $error("ready longer than one cycle");
  chk_refresh_flags: assert property (i_wdt_refresh ##0 s_live |=> o_zsv_we)
    else $error("refresh gave no flag update");
  chk_flags_cause: assert property (o_zsv_we |-> $past(i_wdt_refresh))
    else $error("flag update without refresh");
  chk_stop_enter: assert property (i_stop_req ##0 s_live |=> o_stopped || o_reset)
    else $error("stop request not taken");
  chk_wake_stopped: assert property (o_wake |-> o_reset && $past(o_stopped))
    else $error("wake outside stop");
  chk_lowv_reset: assert property (i_low_voltage |=> o_reset && !o_stopped)
    else $error("low supply without reset");
  chk_stop_exit: assert property (s_left_stop |-> o_reset)
    else $error("stop left without reset");
endmodule
bind srw_top srw_top_monitor u_mon (
  .i_clk         (i_clk),
  .i_nrst        (i_nrst),
  .i_apb         (i_apb),
  .o_apb         (o_apb),
  .i_wdt_refresh (i_wdt_refresh),
  .i_stop_req    (i_stop_req),
  .i_low_voltage (i_low_voltage),
  .o_reset       (o_reset),
  .o_stopped     (o_stopped),
  .o_zsv_we      (o_zsv_we),
  .o_wake        (o_wake)
);
`default_nettype wire

// ### test/srw_far_model.sv
// Purpose: wake pins and oscillator ticks around srw_top
// Assumes: bench raises i_active for one cycle to request a wake
// Notes:   pad input of a driven port 2 pin shows the inverse level
`timescale 1ns/1ps
`default_nettype none
module srw_far_model
  import srw_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // request from bench
  input  wire logic        i_active,
  input  wire logic [11:0] i_lvl,
  input  wire logic [7:0]  i_oe,
  // pins and ticks
  output srw_port2_t       o_port2,
  output logic [3:0]       o_port3,
  output logic             o_rc_tick,
  output logic             o_xtal_tick
);
  logic [2:0]  hold;
  logic [11:0] v;

  // ==========================================================================
  // hold the wake level at least five cycles
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      hold <= 3'h0;
      o_xtal_tick <= 1'b0;
    end else begin
      o_xtal_tick <= ~o_xtal_tick;
      if (i_active) begin
        hold <= 3'h5;
      end else if (hold != 3'h0) begin
        hold <= hold - 3'h1;
      end
    end
  end
  assign v = (i_active || hold != 3'h0) ? i_lvl : ~i_lvl;
  assign o_port3 = v[3:0];
  assign o_port2 = '{pin: v[11:4] ^ i_oe, pout: ~(v[11:4] ^ i_oe), poe: i_oe};
  assign o_rc_tick = i_nrst;
endmodule
`default_nettype wire

// ### test/stop_recovery_watchdog_test.sv
// Purpose: self-checking bench for srw_top
// Assumes: short power-on delay of five cycles
// Notes:   random polarity, delay, clock source and output enables
`timescale 1ns/1ps
`default_nettype none
module stop_recovery_watchdog_test;
  import srw_pkg::*;
  localparam int POR_CYC = 5;
  localparam logic [7:0] A_SMR = {IDX_SMR, 2'b00};
  localparam logic [7:0] A_STOP_RECOVERY_CONTROL_TWO = {IDX_STOP_RECOVERY_CONTROL_TWO, 2'b00};
  localparam logic [7:0] A_WDT = {IDX_WDTM, 2'b00};
  logic         i_clk = 1'b0;
  logic         i_nrst = 1'b0;
  srw_apb_req_t apb_req = '0;
  srw_apb_rsp_t apb_rsp;
  logic         refresh = 1'b0, stop_req = 1'b0, halt = 1'b0;
  logic         lowv = 1'b0, analog = 1'b0, active = 1'b0;
  logic [11:0]  lvl = '0;
  logic [7:0]   oe = '0;
  srw_port2_t   port2;
  logic [3:0]   port3;
  logic         rc_tick, xtal_tick, o_reset, o_stopped, o_zsv_we, o_wake;
  int           errors = 0, checks = 0, cyc = 0, seed = 32'h6f30576b;

  always #4 i_clk = ~i_clk;

  srw_top #(.POR_DELAY_NS(40), .PERMANENT_WDT(1'b0)) DUT (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_apb(apb_req), .o_apb(apb_rsp),
    .i_wdt_refresh(refresh), .i_stop_req(stop_req), .i_halt(halt),
    .i_rc_tick(rc_tick), .i_xtal_tick(xtal_tick), .i_low_voltage(lowv),
    .i_port2(port2), .i_port3(port3), .i_analog_mode(analog),
    .o_reset(o_reset), .o_stopped(o_stopped), .o_zsv_we(o_zsv_we),
    .o_wake(o_wake));
  srw_far_model u_far (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_active(active), .i_lvl(lvl),
    .i_oe(oe), .o_port2(port2), .o_port3(port3), .o_rc_tick(rc_tick),
    .o_xtal_tick(xtal_tick));

  // ==========================================================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge i_clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge i_clk);
    apb_req.penable <= 1'b1;
    // ready and read data are registered at the setup edge and stand up to the access edge
    @(negedge i_clk);
    while (apb_rsp.pready !== 1'b1 && n < 50) begin
      @(negedge i_clk);
      n++;
    end
    if (n >= 50) begin
      errors++;
    end
    r = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    @(posedge i_clk);
    apb_req <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, x);
    check(e, xe);
  endtask
  task automatic fire(input logic stop);
    @(posedge i_clk);
    refresh <= ~stop;
    stop_req <= stop;
    @(posedge i_clk);
    refresh <= 1'b0;
    stop_req <= 1'b0;
    @(negedge i_clk);
  endtask
  task automatic wait_lvl(input logic v, output int n);
    n = 0;
    while (o_reset !== v && n < 5000) begin
      n++;
      @(negedge i_clk);
    end
  endtask
  function automatic int wdt_ticks(input logic [1:0] p);
    return (p == 2'h3) ? 2048 : (128 << p);
  endfunction

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      tally_and_finish;
    end
  end

  // ==========================================================================
  // main sequence
  initial begin
    int n, code, x;
    logic [1:0] per;
    logic xc, pol, dly, ana, exp_w;
    repeat (8) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(negedge i_clk);
    wait_lvl(1'b0, n);
    check(n, POR_CYC);
    rdc(A_SMR, 32'h0, 1'b0);
    rdc(A_STOP_RECOVERY_CONTROL_TWO, 32'h0, 1'b0);
    rdc(A_WDT, 32'h0, 1'b0);
    rdc(8'hFC, 32'h0, 1'b1);
    for (int k = 0; k < 5; k++) begin
      per = k[1:0];
      xc = $random(seed);
      halt <= $random(seed);
      if (k < 4) begin
        wr(A_WDT, {27'h0, xc, 2'b11, per});
      end else begin
        repeat (70) @(posedge i_clk);
        wr(A_WDT, 32'h13);
        per = 2'h1;
        xc = 1'b0;
      end
      fire(1'b0);
      check(o_zsv_we, 1'b1);
      repeat (20) @(posedge i_clk);
      fire(1'b0);
      wait_lvl(1'b1, n);
      x = wdt_ticks(per) * (xc ? 2 : 1);
      check(n > x - 4 && n < x + 4, 1'b1);
      halt <= 1'b0;
      wait_lvl(1'b0, n);
    end
    repeat (300) @(negedge i_clk);
    check(o_reset, 1'b0);
    for (int it = 0; it < 24; it++) begin
      code = it % 10;
      pol = $random(seed);
      dly = $random(seed);
      ana = (it >= 10) ? $random(seed) : 1'b0;
      exp_w = code != 0 && !(ana && code >= 2 && code <= 4);
      oe <= $random(seed);
      lvl <= {12{(code == 6 || code == 7) ? ~pol : pol}};
      analog <= ana;
      wr(A_SMR, {24'h0, pol, dly, (code < 8) ? code[2:0] : 3'h0, 2'b00});
      wr(A_STOP_RECOVERY_CONTROL_TWO, (code < 8) ? 32'h0 : code - 7);
      fire(1'b1);
      check(o_stopped, 1'b1);
      @(posedge i_clk);
      active <= 1'b1;
      @(posedge i_clk);
      active <= 1'b0;
      n = 0;
      while (o_wake !== 1'b1 && n < 10) begin
        @(negedge i_clk);
        n++;
      end
      check(o_wake === 1'b1, exp_w);
      if (exp_w) begin
        wait_lvl(1'b0, n);
        check(n, dly ? POR_CYC : 1);
        rdc(A_SMR, 32'h80, 1'b0);
      end else begin
        @(posedge i_clk);
        lowv <= 1'b1;
        repeat (3) @(posedge i_clk);
        lowv <= 1'b0;
        @(negedge i_clk);
        check(o_reset, 1'b1);
        wait_lvl(1'b0, n);
        rdc(A_SMR, 32'h0, 1'b0);
      end
    end
    // timeout in stop with fast wake chosen still gives the full delay
    analog <= 1'b0;
    wr(A_SMR, 32'h0);
    wr(A_STOP_RECOVERY_CONTROL_TWO, 32'h0);
    fire(1'b0);
    fire(1'b1);
    check(o_stopped, 1'b1);
    wait_lvl(1'b1, n);
    x = wdt_ticks(2'h1);
    check(n > x - 4 && n < x + 4, 1'b1);
    wait_lvl(1'b0, n);
    check(n, POR_CYC);
    rdc(A_SMR, 32'h0, 1'b0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
